// >>> logic/adcc_chan_ctrl.sv
// One channel control register with its run, reset and interrupt gating
`timescale 1ns/1ps
module adcc_chan_ctrl (
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   adcc_cr_if.ctl   cr
);
   logic       run_q;
   logic       rr_q;
   logic [2:0] ie_q;
   logic       ioc_sts_q;
   logic       last_sts_q;

   // Enables survive register reset
   always_ff @(posedge sys_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         ie_q <= adcc_pkg::CTRL_RESET[adcc_pkg::IOC_IE_BIT:adcc_pkg::LVB_IE_BIT];
      else if (cr.wr)
         ie_q <= cr.wdata[adcc_pkg::IOC_IE_BIT:adcc_pkg::LVB_IE_BIT];
   end

   // Run and self-clearing register reset
   always_ff @(posedge sys_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         run_q <= adcc_pkg::CTRL_RESET[adcc_pkg::RUN_BIT];
         rr_q  <= adcc_pkg::CTRL_RESET[adcc_pkg::RR_BIT];
      end
      else if (rr_q)
      begin
         rr_q  <= 1'b0;
         run_q <= 1'b0;
      end
      else if (cr.wr)
      begin
         rr_q  <= cr.wdata[adcc_pkg::RR_BIT];
         run_q <= cr.wdata[adcc_pkg::RUN_BIT];
      end
   end

   // Sticky completion flags, set wins over clear
   always_ff @(posedge sys_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         ioc_sts_q  <= 1'b0;
         last_sts_q <= 1'b0;
      end
      else if (rr_q)
      begin
         ioc_sts_q  <= 1'b0;
         last_sts_q <= 1'b0;
      end
      else
      begin
         if (cr.buf_done && cr.buf_ioc)
            ioc_sts_q <= 1'b1;
         else if (cr.ioc_clr)
            ioc_sts_q <= 1'b0;
         if (cr.last_done)
            last_sts_q <= 1'b1;
         else if (cr.last_clr)
            last_sts_q <= 1'b0;
      end
   end

   assign cr.rdata    = {3'h0, ie_q, rr_q, run_q};
   assign cr.run      = run_q;
   assign cr.rr_pulse = rr_q;
   assign cr.ioc_sts  = ioc_sts_q;
   assign cr.last_sts = last_sts_q;
   assign cr.irq      = (ioc_sts_q && ie_q[2]) || (last_sts_q && ie_q[0]);

   a_ioc_irq_gate: assert property (
      @(posedge sys_clk_in) disable iff (!arst_n_in)
      (cr.buf_done && cr.buf_ioc && !rr_q) |=> (cr.irq == ie_q[2]) || (last_sts_q && ie_q[0]))
      else $error("completion interrupt not gated by its enable");
   a_lvb_irq_gate: assert property (
      @(posedge sys_clk_in) disable iff (!arst_n_in)
      (!ioc_sts_q && last_sts_q) |-> (cr.irq == ie_q[0]))
      else $error("last buffer interrupt not gated by its enable");
   a_status_still_set: assert property (
      @(posedge sys_clk_in) disable iff (!arst_n_in)
      (cr.last_done && !rr_q && !ie_q[0] && !cr.wr) |=> last_sts_q && !(cr.irq && !ioc_sts_q))
      else $error("last buffer status missing when enable clear");
   a_rr_keeps_ie: assert property (
      @(posedge sys_clk_in) disable iff (!arst_n_in)
      (rr_q && !cr.wr) |=> (ie_q == $past(ie_q)) && !run_q && !last_sts_q && !ioc_sts_q)
      else $error("register reset disturbed enables or kept state");
   a_rr_self_clear: assert property (
      @(posedge sys_clk_in) disable iff (!arst_n_in)
      $rose(rr_q) |=> !rr_q)
      else $error("register reset bit did not clear itself");
   a_pause_holds: assert property (
      @(posedge sys_clk_in) disable iff (!arst_n_in)
      (!run_q && !cr.wr && !rr_q) |=> !run_q && (ie_q == $past(ie_q)))
      else $error("paused channel changed state");
   a_run_start: assert property (
      @(posedge sys_clk_in) disable iff (!arst_n_in)
      (cr.wr && !rr_q && cr.wdata[0]) |=> run_q ##1 (run_q || $past(cr.wr) || $past(rr_q)))
      else $error("run bit did not start channel");
   a_irq_drops: assert property (
      @(posedge sys_clk_in) disable iff (!arst_n_in)
      (cr.last_clr && !cr.last_done && !ioc_sts_q && !cr.buf_done) |=> !cr.irq)
      else $error("interrupt stayed after status clear");
   a_reserved_zero: assert property (
      @(posedge sys_clk_in) disable iff (!arst_n_in)
      cr.rdata[7:5] == 3'h0)
      else $error("reserved control bits not zero");
endmodule

// >>> logic/adcc_cr_if.sv
// Signals between the register decoder and one channel control register
`timescale 1ns/1ps
interface adcc_cr_if;
   logic       wr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       run;
   logic       rr_pulse;
   logic       buf_done;
   logic       buf_ioc;
   logic       last_done;
   logic       ioc_clr;
   logic       last_clr;
   logic       ioc_sts;
   logic       last_sts;
   logic       irq;
   modport ctl (input wr, wdata, buf_done, buf_ioc, last_done, ioc_clr, last_clr,
                output rdata, run, rr_pulse, ioc_sts, last_sts, irq);
   modport dec (output wr, wdata, buf_done, buf_ioc, last_done, ioc_clr, last_clr,
                input rdata, run, rr_pulse, ioc_sts, last_sts, irq);
endinterface

// >>> logic/adcc_ctrl_top.sv
// I/O decoder and three channel control registers of the bus-master engines
`timescale 1ns/1ps
module adcc_ctrl_top (
   input  wire logic                                           sys_clk_in,
   input  wire logic                                           arst_n_in,
   input  wire logic [5:0]                                     io_addr_in,
   input  wire logic [3:0]                                     io_be_in,
   input  wire logic                                           io_rd_in,
   input  wire logic                                           io_wr_in,
   input  wire logic [31:0]                                    io_wdata_in,
   output logic      [31:0]                                    io_rdata_out,
   output logic                                                io_ack_out,
   input  wire logic [adcc_pkg::CHAN_COUNT-1:0][adcc_pkg::POS_WIDTH-1:0] buf_pos_in,
   input  wire logic [adcc_pkg::CHAN_COUNT-1:0][adcc_pkg::IDX_WIDTH-1:0] prefetch_idx_in,
   input  wire logic [adcc_pkg::CHAN_COUNT-1:0]                buf_done_in,
   input  wire logic [adcc_pkg::CHAN_COUNT-1:0]                descriptor_completion_flag_in,
   input  wire logic [adcc_pkg::CHAN_COUNT-1:0]                last_done_in,
   input  wire logic [adcc_pkg::CHAN_COUNT-1:0]                completion_status_clr_in,
   input  wire logic [adcc_pkg::CHAN_COUNT-1:0]                last_buffer_done_status_clr_in,
   output logic      [adcc_pkg::CHAN_COUNT-1:0]                run_pause_bit_out,
   output logic      [adcc_pkg::CHAN_COUNT-1:0]                register_reset_bit_out,
   output logic      [adcc_pkg::CHAN_COUNT-1:0]                completion_status_out,
   output logic      [adcc_pkg::CHAN_COUNT-1:0]                last_buffer_done_status_out,
   output logic      [adcc_pkg::CHAN_COUNT-1:0]                chan_irq_out
);
   logic [adcc_pkg::CHAN_COUNT-1:0][31:0] chan_word;
   logic [adcc_pkg::CHAN_COUNT-1:0]       word_hit;
   logic [31:0]                           lane_mask;
   logic [31:0]                           rdata_d;
   logic [31:0]                           rdata_q;
   logic                                  ack_q;

   // Byte lane mask from the enables
   genvar ln;
   generate
      for (ln = 0; ln < 4; ln++)
      begin : g_lane
         assign lane_mask[ln*8 +: 8] = {8{io_be_in[ln]}};
      end
   endgenerate

   // One control register per channel
   genvar ch;
   generate
      for (ch = 0; ch < adcc_pkg::CHAN_COUNT; ch++)
      begin : g_chan
         adcc_cr_if cr_if ();
         // Word holding position, prefetch index and control
         assign word_hit[ch] = io_addr_in[5:2] == adcc_pkg::CTRL_OFFSETS[ch][5:2];
         assign cr_if.wr        = io_wr_in && word_hit[ch] && io_be_in[adcc_pkg::CTRL_LANE];
         assign cr_if.wdata     = io_wdata_in[31:24];
         assign cr_if.buf_done  = buf_done_in[ch];
         assign cr_if.buf_ioc   = descriptor_completion_flag_in[ch];
         assign cr_if.last_done = last_done_in[ch];
         assign cr_if.ioc_clr   = completion_status_clr_in[ch];
         assign cr_if.last_clr  = last_buffer_done_status_clr_in[ch];
         assign chan_word[ch]   = {cr_if.rdata, 3'h0, prefetch_idx_in[ch], buf_pos_in[ch]};
         assign run_pause_bit_out[ch]           = cr_if.run;
         assign register_reset_bit_out[ch]      = cr_if.rr_pulse;
         assign completion_status_out[ch]       = cr_if.ioc_sts;
         assign last_buffer_done_status_out[ch] = cr_if.last_sts;
         assign chan_irq_out[ch]                = cr_if.irq;
         adcc_chan_ctrl u_ctrl (
            .sys_clk_in (sys_clk_in),
            .arst_n_in  (arst_n_in),
            .cr         (cr_if.ctl)
         );
      end
   endgenerate

   // Read data select, unmapped words read zero
   always_comb
   begin
      rdata_d = 32'h0000_0000;
      for (int i = 0; i < adcc_pkg::CHAN_COUNT; i++)
      begin
         if (word_hit[i])
            rdata_d = chan_word[i] & lane_mask;
      end
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         rdata_q <= 32'h0000_0000;
      else if (io_rd_in)
         rdata_q <= rdata_d;
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         ack_q <= 1'b0;
      else
         ack_q <= io_rd_in || io_wr_in;
   end

   assign io_rdata_out = rdata_q;
   assign io_ack_out   = ack_q;

   a_word_read: assert property (
      @(posedge sys_clk_in) disable iff (!arst_n_in)
      (io_rd_in && io_addr_in == {2'b00, adcc_pkg::POS_WORD_OFFSET} && io_be_in == 4'hF)
      |=> io_rdata_out == {$past(chan_word[0][31:24]), 3'h0, $past(prefetch_idx_in[0]), $past(buf_pos_in[0])})
      else $error("dword read at position word wrong");
   a_byte_read: assert property (
      @(posedge sys_clk_in) disable iff (!arst_n_in)
      (io_rd_in && word_hit[1] && io_be_in == 4'h8)
      |=> io_ack_out && io_rdata_out == {$past(chan_word[1][31:24]), 24'h000000})
      else $error("byte read of control register wrong");
   a_decode_write: assert property (
      @(posedge sys_clk_in) disable iff (!arst_n_in)
      (io_wr_in && io_addr_in == adcc_pkg::CTRL_OFFSETS[2] && io_be_in == 4'h8 && !register_reset_bit_out[2]
       && !register_reset_bit_out[0] && io_wdata_in[24])
      |=> run_pause_bit_out[2] && !$changed(run_pause_bit_out[0]))
      else $error("control write reached wrong channel");
endmodule

// >>> logic/adcc_pkg.sv
// Constants shared by the audio DMA channel control logic
// What this block does
// - Completion interrupt fires for flagged buffer completion only while bit 4 is set
// - Last valid buffer interrupt fires only while bit 2 is set
// - Last buffer status still sets when its interrupt enable is clear
// - Register reset clears channel bus-master state but keeps enable bits 4, 3, 2
// - Register reset bit clears itself after the reset is applied
// - Clearing run pauses the channel and keeps all of its state
// - Setting run starts or resumes descriptor processing
// - Three 8-bit control registers at offsets 0Bh, 1Bh and 2Bh
// - A 32-bit read at 08h returns position, prefetch index and control
// - An 8-bit read at 0Bh returns the control register alone
// - Last buffer status drives the interrupt when enabled, clears with the status
package adcc_pkg;
   localparam int              CHAN_COUNT      = 3;
   localparam logic [2:0][5:0] CTRL_OFFSETS    = {6'h2B, 6'h1B, 6'h0B};
   localparam logic [3:0]      POS_WORD_OFFSET = 4'h8;
   localparam logic [1:0]      CTRL_LANE       = 2'h3;
   localparam logic [7:0]      CTRL_RESET      = 8'h00;
   localparam int              RUN_BIT         = 0;
   localparam int              RR_BIT          = 1;
   localparam int              LVB_IE_BIT      = 2;
   localparam int              SPARE_IE_BIT    = 3;
   localparam int              IOC_IE_BIT      = 4;
   localparam int              POS_WIDTH       = 16;
   localparam int              IDX_WIDTH       = 5;
endpackage

// >>> tb/adcc_engine_model.sv
// Bus-master engine model that supplies buffer position and prefetch index
`timescale 1ns/1ps
module adcc_engine_model (
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic [2:0]       run_in,
   input  wire logic [2:0]       rr_in,
   output logic      [2:0][15:0] pos_out,
   output logic      [2:0][4:0]  idx_out
);
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         pos_out <= '0;
         idx_out <= '0;
      end
      else
      begin
         // Paused channels keep position and index
         for (int i = 0; i < 3; i++)
         begin
            if (rr_in[i])
            begin
               pos_out[i] <= 16'h0000;
               idx_out[i] <= 5'h00;
            end
            else if (run_in[i])
            begin
               pos_out[i] <= pos_out[i] + 16'h0001;
               idx_out[i] <= idx_out[i] + 5'h01;
            end
         end
      end
   end
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the channel control registers
`timescale 1ns/1ps
module testbench;
   logic             sys_clk;
   logic             arst_n;
   logic [5:0]       addr;
   logic [3:0]       be;
   logic             rd;
   logic             wr;
   logic [31:0]      wdata;
   logic [31:0]      rdata;
   logic [31:0]      snap;
   logic             ack;
   logic [2:0][15:0] pos;
   logic [2:0][4:0]  idx;
   logic [2:0]       done, flag, last, cclr, lclr, run, rr, csts, lsts, irq;
   int               fails;
   int               checked;

   initial
   begin
      {sys_clk, arst_n, addr, be, rd, wr, wdata} = '0;
      {done, flag, last, cclr, lclr} = '0;
      fails = 0;
      checked = 0;
   end
   always #10 sys_clk = ~sys_clk;

   adcc_ctrl_top u_adcc_ctrl_top (.sys_clk_in(sys_clk), .arst_n_in(arst_n), .io_addr_in(addr),
      .io_be_in(be), .io_rd_in(rd), .io_wr_in(wr), .io_wdata_in(wdata), .io_rdata_out(rdata),
      .io_ack_out(ack), .buf_pos_in(pos), .prefetch_idx_in(idx), .buf_done_in(done),
      .descriptor_completion_flag_in(flag), .last_done_in(last), .completion_status_clr_in(cclr),
      .last_buffer_done_status_clr_in(lclr), .run_pause_bit_out(run), .register_reset_bit_out(rr),
      .completion_status_out(csts), .last_buffer_done_status_out(lsts), .chan_irq_out(irq));
   adcc_engine_model u_adcc_engine_model (.clk_in(sys_clk), .rst_n_in(arst_n), .run_in(run),
      .rr_in(rr), .pos_out(pos), .idx_out(idx));

   task automatic cmp(input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         fails++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic cmp_bit(input logic e, input logic g);
      cmp({31'h0, e}, {31'h0, g});
   endtask
   // Idle cycle, one strobe, answer checked one cycle later
   task automatic bus(input logic w, input logic [5:0] a, input logic [3:0] b, input logic [31:0] d);
      @(negedge sys_clk);
      addr = a;
      be = b;
      wdata = d;
      wr = w;
      rd = !w;
      @(negedge sys_clk);
      wr = 1'b0;
      rd = 1'b0;
      cmp_bit(1'b1, ack);
   endtask
   task automatic wrc(input int ch, input logic [7:0] v);
      bus(1'b1, 6'(ch * 16 + 11), 4'h8, {v, 24'h000000});
   endtask
   task automatic rdc(input int ch, input logic [7:0] v);
      bus(1'b0, 6'(ch * 16 + 11), 4'h8, 32'h00000000);
      cmp({v, 24'h000000}, rdata);
   endtask
   // Idle cycle, then one event: 0 done, 1 flagged done, 2 last, 3 completion clear, 4 last clear
   task automatic pulse(input int sel, input int ch);
      @(negedge sys_clk);
      case (sel)
         0: done[ch] = 1'b1;
         1: {done[ch], flag[ch]} = 2'b11;
         2: last[ch] = 1'b1;
         3: cclr[ch] = 1'b1;
         default: lclr[ch] = 1'b1;
      endcase
      @(negedge sys_clk);
      {done, flag, last, cclr, lclr} = '0;
   endtask

   task automatic t_defaults_and_mask;
      for (int ch = 0; ch < 3; ch++)
      begin
         rdc(ch, 8'h00);
         wrc(ch, 8'hFC);
         rdc(ch, 8'h1C);
         wrc(ch, 8'h00);
      end
      $display("test defaults_and_mask done");
   endtask
   task automatic t_run_pause;
      wrc(0, 8'h01);
      cmp({29'h0, run}, 32'h1);
      bus(1'b0, 6'h0B, 4'h8, 32'h0);
      cmp(32'h01000000, rdata);
      wrc(0, 8'h00);
      bus(1'b0, 6'h08, 4'hF, 32'h0);
      snap = rdata;
      cmp({8'h00, 3'h0, idx[0], pos[0]}, snap);
      cmp_bit(1'b1, pos[0] != 16'h0000);
      repeat (5) @(negedge sys_clk);
      bus(1'b0, 6'h08, 4'hF, 32'h0);
      cmp(snap, rdata);
      wrc(0, 8'h01);
      wrc(0, 8'h00);
      bus(1'b0, 6'h08, 4'hF, 32'h0);
      cmp_bit(1'b1, rdata[15:0] > snap[15:0]);
      wrc(0, 8'h02); // Run is clear here
      bus(1'b0, 6'h08, 4'hF, 32'h0);
      cmp(32'h00000000, rdata);
      $display("test run_pause done");
   endtask
   task automatic t_irq_gating;
      pulse(2, 1);
      cmp_bit(1'b1, lsts[1]);
      cmp_bit(1'b0, irq[1]);
      wrc(1, 8'h04);
      cmp_bit(1'b1, irq[1]);
      pulse(4, 1);
      cmp_bit(1'b0, irq[1]);
      wrc(1, 8'h10);
      pulse(0, 1);
      cmp_bit(1'b0, csts[1]);
      pulse(1, 1);
      cmp_bit(1'b1, irq[1]);
      wrc(1, 8'h00);
      cmp_bit(1'b0, irq[1]);
      pulse(3, 1);
      cmp_bit(1'b0, csts[1]);
      $display("test irq_gating done");
   endtask
   task automatic t_register_reset;
      wrc(2, 8'h1C);
      pulse(2, 2);
      wrc(2, 8'h1E); // Run is clear here
      cmp({29'h0, rr}, 32'h4);
      @(negedge sys_clk);
      cmp({29'h0, rr}, 32'h0);
      cmp_bit(1'b0, lsts[2]);
      rdc(2, 8'h1C);
      wrc(2, 8'h1D);
      cmp({29'h0, run}, 32'h4);
      wrc(2, 8'h1C);
      $display("test register_reset done");
   endtask

   task automatic report_and_stop;
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      #200us;
      fails++;
      report_and_stop();
   end
   initial
   begin
      repeat (8) @(negedge sys_clk);
      arst_n = 1'b1;
      t_defaults_and_mask();
      t_run_pause();
      t_irq_gating();
      t_register_reset();
      report_and_stop();
   end
endmodule
